/* hw/pdc_defs.svh */
// constants for the dual synthesizer divider chain
// assumes: included by its bare name from the package, top and checker files
`ifndef PDC_DEFS_SVH
`define PDC_DEFS_SVH

// ========================================================
// serial word and latch selection
`define PDC_WORD_W 24
`define PDC_DEST_IF_R 2'h0
`define PDC_DEST_IF_N 2'h1
`define PDC_DEST_RF_R 2'h2
`define PDC_DEST_RF_N 2'h3
`define PDC_LATCH_RST 24'h000000

// ========================================================
// register port offsets
`define PDC_ADDR_W 3
`define PDC_ADDR_IF_R 3'h0
`define PDC_ADDR_IF_N 3'h1
`define PDC_ADDR_RF_R 3'h2
`define PDC_ADDR_RF_N 3'h3
`define PDC_ADDR_STATUS 3'h4

// ========================================================
// field positions inside the latches
`define PDC_SHARED_BIT 23
`define PDC_FRAC16_BIT 22
`define PDC_IF_POL_BIT 18
`define PDC_RF_POL_BIT 17
`define PDC_R_HI 16
`define PDC_R_LO 2
`define PDC_IF_A_HI 4
`define PDC_IF_A_LO 2
`define PDC_IF_B_HI 16
`define PDC_IF_B_LO 5
`define PDC_FRAC_HI 5
`define PDC_FRAC_LO 2
`define PDC_RF_A_LO 6
`define PDC_HB_A_HI 10
`define PDC_HB_B_HI 20
`define PDC_HB_B_LO 11
`define PDC_LB_A_HI 9
`define PDC_LB_B_HI 19
`define PDC_LB_B_LO 10
`define PDC_RF_PS_BIT 21

// ========================================================
// prescaler bases and fraction denominators
`define PDC_PRE_W 6
`define PDC_HB_PRE_LO 6'h10
`define PDC_HB_PRE_HI 6'h20
`define PDC_LB_PRE_LO 6'h08
`define PDC_LB_PRE_HI 6'h10
`define PDC_IF_PRE 6'h08
`define PDC_DEN_15 5'h0f
`define PDC_DEN_16 5'h10

`endif

/* hw/pdc_pkg.sv */
// types shared by the divider chain design files
// assumes: pdc_defs.svh sits beside it
package pdc_pkg;
  `include "pdc_defs.svh"

  typedef logic [`PDC_WORD_W-1:0] pdc_latch_t;

  // phase detector state, one-hot
  typedef enum logic [2:0] {
    PDC_PFD_IDLE = 3'b001,
    PDC_PFD_UP = 3'b010,
    PDC_PFD_DOWN = 3'b100
  } pdc_pfd_e;
endpackage : pdc_pkg

/* hw/pdc_dual_mod_div.sv */
// dual-modulus feedback divider: prescaler, swallow and main counters
// assumes: vco_tick is a one-cycle pulse per vco edge, main >= swallow
`timescale 1ns/10ps
module pdc_dual_mod_div #(
  parameter int A_W = 5,
  parameter int B_W = 10,
  parameter int P_W = 6
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic vco_tick,
  input wire logic [P_W-1:0] modulus_base,
  input wire logic [A_W-1:0] a_value,
  input wire logic [B_W-1:0] b_value,
  input wire logic extra_swallow,
  output logic cycle_pulse
);
  logic [P_W-1:0] pre_q;
  logic [A_W:0] a_q;
  logic [B_W-1:0] b_q;
  logic [P_W-1:0] pre_last;
  logic pre_out;

  // swallow counter holds the prescaler at P+1 until it runs out
  assign pre_last = (a_q != '0) ? modulus_base : modulus_base - 1'b1;
  assign pre_out = vco_tick && (pre_q == pre_last);

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pre_q <= '0;
    end else if (pre_out) begin
      pre_q <= '0;
    end else if (vco_tick) begin
      pre_q <= pre_q + 1'b1;
    end
  end

  // one extra swallow stretches the next cycle by a single vco period
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      a_q <= '0;
      b_q <= '0;
      cycle_pulse <= 1'b0;
    end else begin
      cycle_pulse <= 1'b0;
      if (pre_out) begin
        if (b_q <= {{(B_W-1){1'b0}}, 1'b1}) begin
          a_q <= {1'b0, a_value} + (A_W+1)'(extra_swallow);
          b_q <= b_value;
          cycle_pulse <= 1'b1;
        end else begin
          b_q <= b_q - 1'b1;
          if (a_q != '0) begin
            a_q <= a_q - 1'b1;
          end
        end
      end
    end
  end
endmodule : pdc_dual_mod_div

/* hw/pdc_top.sv */
// dual synthesizer divider chain: references, feedback, fraction, detectors
// assumes: all pins synchronous to clock, edges seen as level changes
//
// What this block does
// - shared select high drives both reference dividers from one input
// - separate mode: primary feeds IF reference, secondary feeds RF
// - each reference divider is 15 bits, ratio 3 to 32767
// - high band RF divider: 5-bit swallow, 10-bit main, 4-bit fraction
// - high band ranges 1056-32767 at 32/33, 272-16399 at 16/17
// - low band RF divider: 4-bit swallow, 10-bit main, 4-bit fraction
// - low band ranges 72-8199 at 8/9, 272-16383 at 16/17
// - IF divider: 3-bit swallow, 12-bit main, range 56 to 32767
// - IF feedback divides by integers only, no fraction logic
// - prescaler clocks swallow and main; swallow steers the modulus
// - RF modulus selectable per band; IF prescaler fixed 8/9
// - fraction has 4-bit numerator, denominator 15 or 16
// - accumulator overflow swallows one extra vco cycle
// - feedback edge delayed by accumulated fractional phase
// - locked RF vco runs at integer plus fraction times comparison
// - each detector compares own reference and own feedback
// - detector drives pump; polarity bit swaps up and down
// - serial words enter MSB first on rising clock, 24 bits
// - low two bits choose which of four latches is written
// - rising load strobe copies the word into the chosen latch
`timescale 1ns/10ps
`include "pdc_defs.svh"
module pdc_top
  import pdc_pkg::*;
#(
  parameter bit HIGH_BAND = 1'b1,
  parameter int R_W = 15,
  parameter int FRAC_W = 4
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic reference_input_primary,
  input wire logic reference_input_secondary,
  input wire logic rf_vco_input,
  input wire logic if_vco_input,
  input wire logic serial_clock,
  input wire logic serial_data,
  input wire logic load_strobe,
  input wire logic [`PDC_ADDR_W-1:0] address,
  input wire logic [`PDC_WORD_W-1:0] write_data,
  input wire logic write_strobe,
  input wire logic read_strobe,
  output logic [`PDC_WORD_W-1:0] read_data,
  output logic rf_pump_output_up,
  output logic rf_pump_output_down,
  output logic if_pump_output_up,
  output logic if_pump_output_down
);
  import pdc_pkg::*;

  localparam int RF_A_W = HIGH_BAND ? 5 : 4;
  localparam int RF_A_PORT = 5;
  localparam int RF_B_W = 10;
  localparam int IF_A_W = 3;
  localparam int IF_B_W = 12;
  localparam int DEN_W = FRAC_W + 1;

  // ========================================================
  // helpers
  function automatic logic pdc_rising(input logic now_v, input logic was_v);
    pdc_rising = now_v & ~was_v;
  endfunction : pdc_rising

  // ========================================================
  // pin edge detection
  logic prim_q;
  logic sec_q;
  logic rf_vco_q;
  logic if_vco_q;
  logic sclk_q;
  logic load_q;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      prim_q <= 1'b0;
      sec_q <= 1'b0;
      rf_vco_q <= 1'b0;
      if_vco_q <= 1'b0;
      sclk_q <= 1'b0;
      load_q <= 1'b0;
    end else begin
      prim_q <= reference_input_primary;
      sec_q <= reference_input_secondary;
      rf_vco_q <= rf_vco_input;
      if_vco_q <= if_vco_input;
      sclk_q <= serial_clock;
      load_q <= load_strobe;
    end
  end

  logic prim_tick;
  logic sec_tick;
  logic rf_vco_tick;
  logic if_vco_tick;
  logic sclk_tick;
  logic load_tick;

  assign prim_tick = pdc_rising(reference_input_primary, prim_q);
  assign sec_tick = pdc_rising(reference_input_secondary, sec_q);
  assign rf_vco_tick = pdc_rising(rf_vco_input, rf_vco_q);
  assign if_vco_tick = pdc_rising(if_vco_input, if_vco_q);
  assign sclk_tick = pdc_rising(serial_clock, sclk_q);
  assign load_tick = pdc_rising(load_strobe, load_q);

  // ========================================================
  // serial shift register and latches
  pdc_latch_t shift_q;
  pdc_latch_t latch_q [4];

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      shift_q <= `PDC_LATCH_RST;
    end else if (sclk_tick) begin
      shift_q <= {shift_q[`PDC_WORD_W-2:0], serial_data};
    end
  end

  // a bus write in the same cycle as a load strobe wins its latch
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 4; i++) begin
        latch_q[i] <= `PDC_LATCH_RST;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (load_tick && (shift_q[1:0] == 2'(i))) begin
          latch_q[i] <= shift_q;
        end
        if (write_strobe && (address == 3'(i))) begin
          latch_q[i] <= write_data;
        end
      end
    end
  end

  pdc_latch_t if_r;
  pdc_latch_t if_n;
  pdc_latch_t rf_r;
  pdc_latch_t rf_n;

  assign if_r = latch_q[`PDC_DEST_IF_R];
  assign if_n = latch_q[`PDC_DEST_IF_N];
  assign rf_r = latch_q[`PDC_DEST_RF_R];
  assign rf_n = latch_q[`PDC_DEST_RF_N];

  logic shared_reference_select;
  logic frac_den16;
  logic if_detector_polarity;
  logic rf_detector_polarity;

  assign shared_reference_select = if_r[`PDC_SHARED_BIT];
  assign frac_den16 = if_r[`PDC_FRAC16_BIT];
  assign if_detector_polarity = if_r[`PDC_IF_POL_BIT];
  assign rf_detector_polarity = rf_r[`PDC_RF_POL_BIT];

  // ========================================================
  // reference dividers, index 0 is IF and 1 is RF
  logic [1:0] ref_tick;
  logic [R_W-1:0] ref_ratio [2];
  logic [R_W-1:0] ref_cnt_q [2];
  logic [1:0] ref_pulse_q;

  assign ref_tick[0] = prim_tick;
  assign ref_tick[1] = shared_reference_select ? prim_tick : sec_tick;
  assign ref_ratio[0] = if_r[`PDC_R_HI:`PDC_R_LO];
  assign ref_ratio[1] = rf_r[`PDC_R_HI:`PDC_R_LO];

  generate
    for (genvar g = 0; g < 2; g++) begin : g_ref
      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          ref_cnt_q[g] <= '0;
          ref_pulse_q[g] <= 1'b0;
        end else begin
          ref_pulse_q[g] <= 1'b0;
          if (ref_tick[g]) begin
            if (ref_cnt_q[g] >= ref_ratio[g] - 1'b1) begin
              ref_cnt_q[g] <= '0;
              ref_pulse_q[g] <= 1'b1;
            end else begin
              ref_cnt_q[g] <= ref_cnt_q[g] + 1'b1;
            end
          end
        end
      end
    end
  endgenerate

  // ========================================================
  // RF feedback fields per band
  logic [RF_A_PORT-1:0] rf_a_value;
  logic [RF_B_W-1:0] rf_b_value;
  logic [`PDC_PRE_W-1:0] rf_pre_base;
  logic [FRAC_W-1:0] frac_num;

  always_comb begin
    if (HIGH_BAND) begin
      rf_a_value = rf_n[`PDC_HB_A_HI:`PDC_RF_A_LO];
      rf_b_value = rf_n[`PDC_HB_B_HI:`PDC_HB_B_LO];
    end else begin
      rf_a_value = {1'b0, rf_n[`PDC_LB_A_HI:`PDC_RF_A_LO]};
      rf_b_value = rf_n[`PDC_LB_B_HI:`PDC_LB_B_LO];
    end
  end

  always_comb begin
    if (HIGH_BAND) begin
      rf_pre_base = rf_n[`PDC_RF_PS_BIT] ? `PDC_HB_PRE_HI : `PDC_HB_PRE_LO;
    end else begin
      rf_pre_base = rf_n[`PDC_RF_PS_BIT] ? `PDC_LB_PRE_HI : `PDC_LB_PRE_LO;
    end
  end

  assign frac_num = rf_n[`PDC_FRAC_HI:`PDC_FRAC_LO];

  // ========================================================
  // fractional accumulator
  logic [FRAC_W-1:0] acc_q;
  logic overflow_q;
  logic rf_fb_pulse;
  logic [DEN_W-1:0] den;
  logic [DEN_W-1:0] acc_sum;

  assign den = frac_den16 ? `PDC_DEN_16 : `PDC_DEN_15;
  assign acc_sum = {1'b0, acc_q} + {1'b0, frac_num};

  // overflow stays up until the next divider reload consumes it
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      acc_q <= '0;
      overflow_q <= 1'b0;
    end else if (rf_fb_pulse) begin
      if (acc_sum >= den) begin
        acc_q <= FRAC_W'(acc_sum - den);
        overflow_q <= 1'b1;
      end else begin
        acc_q <= FRAC_W'(acc_sum);
        overflow_q <= 1'b0;
      end
    end
  end

  // ========================================================
  // feedback dividers
  // RF dual modulus with extra swallow
  pdc_dual_mod_div #(
    .A_W(RF_A_PORT),
    .B_W(RF_B_W),
    .P_W(`PDC_PRE_W)
  ) u_rf_div (
    .clock(clock),
    .reset(reset),
    .vco_tick(rf_vco_tick),
    .modulus_base(rf_pre_base),
    .a_value(rf_a_value),
    .b_value(rf_b_value),
    .extra_swallow(overflow_q),
    .cycle_pulse(rf_fb_pulse)
  );

  logic if_fb_pulse;

  pdc_dual_mod_div #(
    .A_W(IF_A_W),
    .B_W(IF_B_W),
    .P_W(`PDC_PRE_W)
  ) u_if_div (
    .clock(clock),
    .reset(reset),
    .vco_tick(if_vco_tick),
    .modulus_base(`PDC_IF_PRE),
    .a_value(if_n[`PDC_IF_A_HI:`PDC_IF_A_LO]),
    .b_value(if_n[`PDC_IF_B_HI:`PDC_IF_B_LO]),
    .extra_swallow(1'b0),
    .cycle_pulse(if_fb_pulse)
  );

  // ========================================================
  // phase delay stage on the RF feedback edge
  logic [FRAC_W-1:0] dly_q;
  logic dly_busy_q;
  logic rf_fb_delayed_q;

  // delay by accumulated phase in vco periods
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      dly_q <= '0;
      dly_busy_q <= 1'b0;
      rf_fb_delayed_q <= 1'b0;
    end else begin
      rf_fb_delayed_q <= 1'b0;
      if (rf_fb_pulse) begin
        if (acc_q == '0) begin
          rf_fb_delayed_q <= 1'b1;
          dly_busy_q <= 1'b0;
        end else begin
          dly_q <= acc_q;
          dly_busy_q <= 1'b1;
        end
      end else if (dly_busy_q && rf_vco_tick) begin
        if (dly_q == {{(FRAC_W-1){1'b0}}, 1'b1}) begin
          rf_fb_delayed_q <= 1'b1;
          dly_busy_q <= 1'b0;
        end
        dly_q <= dly_q - 1'b1;
      end
    end
  end

  // ========================================================
  // phase frequency detectors, index 0 is IF and 1 is RF
  logic [1:0] fb_pulse;
  logic [1:0] polarity;
  pdc_pfd_e pfd_q [2];
  pdc_pfd_e pfd_d [2];
  logic [1:0] up_q;
  logic [1:0] down_q;

  assign fb_pulse[0] = if_fb_pulse;
  assign fb_pulse[1] = rf_fb_delayed_q;
  assign polarity[0] = if_detector_polarity;
  assign polarity[1] = rf_detector_polarity;

  generate
    for (genvar g = 0; g < 2; g++) begin : g_pfd
      always_comb begin
        pfd_d[g] = pfd_q[g];
        unique case (pfd_q[g])
          PDC_PFD_IDLE: begin
            if (ref_pulse_q[g] && !fb_pulse[g]) begin
              pfd_d[g] = PDC_PFD_UP;
            end else if (fb_pulse[g] && !ref_pulse_q[g]) begin
              pfd_d[g] = PDC_PFD_DOWN;
            end
          end
          PDC_PFD_UP: begin
            if (fb_pulse[g]) begin
              pfd_d[g] = PDC_PFD_IDLE;
            end
          end
          PDC_PFD_DOWN: begin
            if (ref_pulse_q[g]) begin
              pfd_d[g] = PDC_PFD_IDLE;
            end
          end
          default: begin
            pfd_d[g] = PDC_PFD_IDLE;
          end
        endcase
      end

      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          pfd_q[g] <= PDC_PFD_IDLE;
          up_q[g] <= 1'b0;
          down_q[g] <= 1'b0;
        end else begin
          pfd_q[g] <= pfd_d[g];
          up_q[g] <= polarity[g] ? (pfd_d[g] == PDC_PFD_UP)
                                 : (pfd_d[g] == PDC_PFD_DOWN);
          down_q[g] <= polarity[g] ? (pfd_d[g] == PDC_PFD_DOWN)
                                   : (pfd_d[g] == PDC_PFD_UP);
        end
      end
    end
  endgenerate

  assign if_pump_output_up = up_q[0];
  assign if_pump_output_down = down_q[0];
  assign rf_pump_output_up = up_q[1];
  assign rf_pump_output_down = down_q[1];

  // ========================================================
  // register read port
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      read_data <= '0;
    end else if (read_strobe) begin
      unique case (address)
        `PDC_ADDR_IF_R: read_data <= if_r;
        `PDC_ADDR_IF_N: read_data <= if_n;
        `PDC_ADDR_RF_R: read_data <= rf_r;
        `PDC_ADDR_RF_N: read_data <= rf_n;
        `PDC_ADDR_STATUS: begin
          read_data <= {14'h0000, overflow_q, dly_busy_q, acc_q,
                        down_q, up_q};
        end
        default: read_data <= '0;
      endcase
    end else begin
      read_data <= '0;
    end
  end
endmodule : pdc_top

/* sim/pdc_top_checker.sv */
// concurrent checks on the divider chain top ports
// assumes: bound to pdc_top, one clock domain, async reset high
`timescale 1ns/10ps
`include "pdc_defs.svh"
module pdc_top_checker
  import pdc_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic reference_input_primary,
  input wire logic reference_input_secondary,
  input wire logic rf_vco_input,
  input wire logic if_vco_input,
  input wire logic load_strobe,
  input wire logic [`PDC_ADDR_W-1:0] address,
  input wire logic [`PDC_WORD_W-1:0] write_data,
  input wire logic write_strobe,
  input wire logic read_strobe,
  input wire logic [`PDC_WORD_W-1:0] read_data,
  input wire logic rf_pump_output_up,
  input wire logic rf_pump_output_down,
  input wire logic if_pump_output_up,
  input wire logic if_pump_output_down
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // ========================================================
  // quiet counters: cycles since the last possible cause
  logic [7:0] quiet_rf_q;
  logic [7:0] quiet_if_q;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      quiet_rf_q <= 8'h00;
    end else if ($changed(reference_input_primary) || write_strobe ||
                 $changed(reference_input_secondary) ||
                 $changed(rf_vco_input) || $changed(load_strobe)) begin
      quiet_rf_q <= 8'h00;
    end else if (quiet_rf_q != 8'hff) begin
      quiet_rf_q <= quiet_rf_q + 8'h01;
    end
  end
  // secondary is left out: it never feeds the IF loop when separate
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      quiet_if_q <= 8'h00;
    end else if ($changed(reference_input_primary) || write_strobe ||
                 $changed(if_vco_input) || $changed(load_strobe)) begin
      quiet_if_q <= 8'h00;
    end else if (quiet_if_q != 8'hff) begin
      quiet_if_q <= quiet_if_q + 8'h01;
    end
  end
  // ========================================================
  // assertions
  a_rf_pump_exclusive: assert property (!(rf_pump_output_up && rf_pump_output_down))
    else $error("rf pump up and down together");
  a_if_pump_exclusive: assert property (!(if_pump_output_up && if_pump_output_down))
    else $error("if pump up and down together");
  a_rf_pump_cause: assert property ($changed({rf_pump_output_up, rf_pump_output_down}) |-> quiet_rf_q < 8'h0c)
    else $error("rf pump moved without a cause");
  a_if_pump_cause: assert property ($changed({if_pump_output_up, if_pump_output_down}) |-> quiet_if_q < 8'h0c)
    else $error("if pump moved without a cause");
  a_read_idle_zero: assert property (!$past(read_strobe) |-> read_data == 24'h000000)
    else $error("read data outside its cycle");
  a_unmapped_read_zero: assert property (read_strobe && address > 3'h4 |=> read_data == 24'h000000)
    else $error("unmapped offset read nonzero");
  a_status_upper_zero: assert property (read_strobe && address == 3'h4 |=> read_data[23:10] == 14'h0000)
    else $error("status upper bits nonzero");
  a_write_readback: assert property ((write_strobe && address < 3'h4 && !load_strobe) ##1 (!write_strobe && !load_strobe) ##1 (read_strobe && address == $past(address, 2) && !load_strobe) |=> read_data == $past(write_data, 3))
    else $error("latch read back differs from write");
endmodule : pdc_top_checker

/* sim/pdc_wave_model.sv */
// square wave source standing in for a reference or a vco
// assumes: run is held until the wanted edge has been seen
`timescale 1ns/10ps
module pdc_wave_model #(
  parameter int HALF = 8
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic run,
  output logic level,
  output logic [15:0] edges
);
  logic run_q;
  logic [7:0] cnt_q;
  // ========================================================
  // gated wave: stops low so edge counts stay exact per run
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      run_q <= 1'b0;
      cnt_q <= 8'h00;
      level <= 1'b0;
      edges <= 16'h0000;
    end else begin
      run_q <= run;
      if (!run && !level) begin
        cnt_q <= 8'h00;
      end else if (cnt_q == 8'(HALF - 1)) begin
        cnt_q <= 8'h00;
        level <= !level;
        if (!level) begin
          edges <= edges + 16'h0001;
        end
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
      if (run && !run_q) begin
        edges <= 16'h0000;
      end
    end
  end
endmodule : pdc_wave_model

/* sim/testbench.sv */
// self-checking bench for the divider chain top
// assumes: four wave models drive references and vcos, bus by tasks
`timescale 1ns/10ps
module testbench;
  import pdc_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic serial_clock = 1'b0;
  logic serial_data = 1'b0;
  logic load_strobe = 1'b0;
  logic [2:0] address = 3'h0;
  logic [23:0] write_data = 24'h000000;
  logic write_strobe = 1'b0;
  logic read_strobe = 1'b0;
  logic [23:0] read_data;
  logic [3:0] run = 4'h0;
  logic [3:0] lvl;
  logic [63:0] edges;
  logic rf_up, rf_dn, if_up, if_dn;
  wire logic [1:0] act = {rf_up | rf_dn, if_up | if_dn};
  wire logic [1:0] ups = {rf_up, if_up};
  int n_errors = 0;
  int n_compared = 0;
  int acc_model = 0;
  initial begin
    forever #10 clock = ~clock;
  end
  pdc_wave_model #(.HALF(2)) wave_u [3:0] (.clock(clock), .reset(reset),
    .run(run), .level(lvl), .edges(edges));
  pdc_top dut_u (.clock(clock), .reset(reset),
    .reference_input_primary(lvl[0]), .reference_input_secondary(lvl[1]),
    .rf_vco_input(lvl[2]), .if_vco_input(lvl[3]),
    .serial_clock(serial_clock), .serial_data(serial_data),
    .load_strobe(load_strobe), .address(address), .write_data(write_data),
    .write_strobe(write_strobe), .read_strobe(read_strobe),
    .read_data(read_data), .rf_pump_output_up(rf_up),
    .rf_pump_output_down(rf_dn), .if_pump_output_up(if_up),
    .if_pump_output_down(if_dn));
  // ========================================================
  // word builders and shared tasks
  function automatic logic [23:0] w_if_r(logic sh, logic d16, logic pol,
                                         logic [14:0] r);
    return {sh, d16, 3'h0, pol, 1'h0, r, 2'h0};
  endfunction : w_if_r
  function automatic logic [23:0] w_rf_n(logic ps, logic [9:0] b,
                                         logic [4:0] a, logic [3:0] num);
    return {2'h0, ps, b, a, num, 2'h3};
  endfunction : w_rf_n
  task automatic give_verdict();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict
  task automatic check_word(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t word %h expected %h", $time, got, exp);
    end
  endtask : check_word
  task automatic check_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t flag %b expected %b", $time, got, exp);
    end
  endtask : check_bit
  task automatic bus_write(input logic [2:0] a, input logic [23:0] d);
    @(posedge clock);
    write_strobe <= 1'b1;
    address <= a;
    write_data <= d;
    @(posedge clock);
    write_strobe <= 1'b0;
  endtask : bus_write
  task automatic bus_read(input logic [2:0] a, output logic [23:0] d);
    @(posedge clock);
    read_strobe <= 1'b1;
    address <= a;
    @(posedge clock);
    read_strobe <= 1'b0;
    #1 d = read_data;
  endtask : bus_read
  task automatic shift_word(input logic [23:0] w);
    int i;
    for (i = 23; i >= 0; i--) begin
      @(posedge clock);
      serial_data <= w[i];
      serial_clock <= 1'b1;
      @(posedge clock);
      serial_clock <= 1'b0;
    end
    @(posedge clock);
    load_strobe <= 1'b1;
    @(posedge clock);
    load_strobe <= 1'b0;
  endtask : shift_word
  task automatic wait_act(input int lp, input logic val);
    int i;
    for (i = 0; i < 20000 && act[lp] !== val; i++) begin
      @(posedge clock);
      #1;
    end
    if (i == 20000) begin
      n_errors++;
      $display("MISMATCH %0t detector wait ran out", $time);
      give_verdict();
    end
  endtask : wait_act
  // one comparison: reference ticks to activity, vco ticks back to idle
  task automatic measure(input int rc, input int vc, input int lp,
                         output logic [15:0] r, output logic [15:0] n,
                         output logic u);
    run[rc] <= 1'b1;
    wait_act(lp, 1'b1);
    u = ups[lp];
    run[rc] <= 1'b0;
    repeat (20) @(posedge clock);
    r = edges[rc*16 +: 16];
    run[vc] <= 1'b1;
    wait_act(lp, 1'b0);
    run[vc] <= 1'b0;
    repeat (20) @(posedge clock);
    n = edges[vc*16 +: 16];
  endtask : measure
  // ========================================================
  // scenarios
  task automatic test_regs();
    logic [23:0] d;
    int a;
    for (a = 0; a < 8; a++) begin
      bus_read(3'(a), d);
      check_word(d, 24'h000000);
    end
    bus_write(3'h6, 24'hffffff);
    bus_write(3'h4, 24'hffffff);
    bus_read(3'h6, d);
    check_word(d, 24'h000000);
    bus_read(3'h4, d);
    check_word(d, 24'h000000);
    for (a = 0; a < 4; a++) begin
      bus_write(3'(a), 24'ha5c3f0 ^ 24'(a));
      bus_read(3'(a), d);
      check_word(d, 24'ha5c3f0 ^ 24'(a));
    end
  endtask : test_regs
  task automatic test_serial();
    logic [23:0] w [4];
    logic [23:0] d;
    int k;
    w[0] = w_rf_n(1'b0, 10'h011, 5'h01, 4'h0);
    w[1] = w_if_r(1'b0, 1'b1, 1'b1, 15'h0003);
    // main count kept at or above the swallow count
    // B not below A
    w[2] = {7'h00, 12'h007, 3'h3, 2'h1};
    w[3] = {6'h00, 1'b1, 15'h0004, 2'h2};
    for (k = 0; k < 4; k++) begin
      shift_word(w[k]);
    end
    for (k = 0; k < 4; k++) begin
      bus_read({1'b0, w[k][1:0]}, d);
      check_word(d, w[k]);
    end
  endtask : test_serial
  task automatic test_if_loop();
    logic [15:0] r, n;
    logic u;
    measure(0, 3, 0, r, n, u);
    measure(0, 3, 0, r, n, u);
    check_word(24'(r), 24'h000003);
    check_word(24'(n), 24'h00003b);
    check_bit(u, 1'b1);
    check_bit(act[1], 1'b0);
    bus_write(3'h0, w_if_r(1'b0, 1'b1, 1'b0, 15'h0003));
    measure(0, 3, 0, r, n, u);
    check_bit(u, 1'b0);
    check_word(24'(n), 24'h00003b);
  endtask : test_if_loop
  task automatic test_rf_int();
    logic [15:0] r, n;
    logic u;
    measure(1, 2, 1, r, n, u);
    measure(1, 2, 1, r, n, u);
    check_word(24'(r), 24'h000004);
    check_word(24'(n), 24'h000111);
    check_bit(act[0], 1'b0);
    bus_write(3'h3, w_rf_n(1'b1, 10'h021, 5'h01, 4'h0));
    measure(1, 2, 1, r, n, u);
    measure(1, 2, 1, r, n, u);
    check_word(24'(n), 24'h000421);
  endtask : test_rf_int
  task automatic test_frac(input logic d16, input logic [3:0] num);
    logic [15:0] r, n;
    logic [23:0] d;
    logic u;
    int den, k, sum;
    den = d16 ? 16 : 15;
    sum = 0;
    bus_write(3'h0, w_if_r(1'b0, d16, 1'b1, 15'h0003));
    bus_write(3'h3, w_rf_n(1'b0, 10'h011, 5'h01, num));
    // first two skipped: old setting, and overflow is used one reload late
    for (k = 0; k <= den + 1; k++) begin
      measure(1, 2, 1, r, n, u);
      acc_model = (acc_model + int'(num)) % den;
      bus_read(3'h4, d);
      check_word(24'(d[7:4]), 24'(acc_model));
      if (k > 1) begin
        sum += int'(n);
      end
    end
    check_word(24'(sum), 24'(den * 273 + int'(num)));
  endtask : test_frac
  task automatic test_shared();
    bus_write(3'h0, w_if_r(1'b1, 1'b0, 1'b1, 15'h0003));
    run[0] <= 1'b1;
    wait_act(1, 1'b1);
    wait_act(0, 1'b1);
    run[0] <= 1'b0;
    check_bit(act[1] & act[0], 1'b1);
  endtask : test_shared
  // ========================================================
  // main sequence
  initial begin
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    test_regs();
    test_serial();
    test_if_loop();
    test_rf_int();
    test_frac(1'b1, 4'h5);
    test_frac(1'b0, 4'h7);
    test_shared();
    give_verdict();
  end
endmodule : testbench

bind pdc_top pdc_top_checker chk_u (.clock(clock), .reset(reset),
  .reference_input_primary(reference_input_primary),
  .reference_input_secondary(reference_input_secondary),
  .rf_vco_input(rf_vco_input), .if_vco_input(if_vco_input),
  .load_strobe(load_strobe), .address(address), .write_data(write_data),
  .write_strobe(write_strobe), .read_strobe(read_strobe),
  .read_data(read_data), .rf_pump_output_up(rf_pump_output_up),
  .rf_pump_output_down(rf_pump_output_down),
  .if_pump_output_up(if_pump_output_up),
  .if_pump_output_down(if_pump_output_down));
